// >>> tmc_pkg.sv
package tmc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] TMC_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] TMC_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] TMC_ADDR_CTRL_C = 4'h2;
  localparam logic [3:0] TMC_ADDR_CNT_LO = 4'h3;
  localparam logic [3:0] TMC_ADDR_CNT_HI = 4'h4;
  localparam logic [3:0] TMC_ADDR_OCA_LO = 4'h5;
  localparam logic [3:0] TMC_ADDR_OCA_HI = 4'h6;
  localparam logic [3:0] TMC_ADDR_CAP_LO = 4'h7;
  localparam logic [3:0] TMC_ADDR_CAP_HI = 4'h8;
  localparam logic [3:0] TMC_ADDR_STATUS = 4'h9;
  localparam logic [3:0] TMC_ADDR_MASK = 4'ha;
  // Control B fields
  localparam int TMC_B_FILT = 7;
  localparam int TMC_B_EDGE = 6;
  localparam int TMC_B_RSVD = 5;
  localparam int TMC_B_WGM_HI = 3;
  localparam int TMC_B_CS = 0;
  localparam logic [7:0] TMC_B_WMASK = 8'hdf;
  // Control C force bits
  localparam int TMC_C_FOC_A = 7;
  localparam int TMC_C_FOC_C = 5;
  // Status bits
  localparam int TMC_ST_OVF = 0;
  localparam int TMC_ST_CAP = 1;
  localparam logic [7:0] TMC_RESET_VAL = 8'h00;
  // TOP values
  localparam logic [15:0] TMC_TOP_MAX = 16'hffff;
  localparam logic [15:0] TMC_TOP_8 = 16'h00ff;
  localparam logic [15:0] TMC_TOP_9 = 16'h01ff;
  localparam logic [15:0] TMC_TOP_10 = 16'h03ff;
  // Prescale terminal counts
  localparam logic [9:0] TMC_DIV8 = 10'h007;
  localparam logic [9:0] TMC_DIV64 = 10'h03f;
  localparam logic [9:0] TMC_DIV256 = 10'h0ff;
  localparam logic [9:0] TMC_DIV1024 = 10'h3ff;
  localparam int TMC_FILT_SAMPLES = 4;
  typedef enum logic [1:0] {
    TMC_UPD_NOW = 2'b00,
    TMC_UPD_TOP = 2'b01,
    TMC_UPD_BOT = 2'b10
  } tmc_upd_t;
endpackage : tmc_pkg

// >>> tmc_timer.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
//Contract
//- Waveform mode is control A bits 1:0 plus control B bits 4:3.
//- Mode 0 counts to 0xFFFF, updates compare at once, overflow at MAX.
//- Mode 4 TOP is compare A, mode 12 capture; immediate update; 13 reserved.
//- Fixed TOPs 0xFF, 0x1FF, 0x3FF for modes 1-3 and 5-7.
//- Phase-correct modes load compare at TOP, overflow at BOTTOM.
//- Modes 8 and 9 load compare at BOTTOM, overflow at BOTTOM.
//- Fast PWM modes load compare at BOTTOM, overflow at TOP.
//- Filter enable needs four equal samples before the capture input changes.
//- Edge select: zero falling, one rising capture edge.
//- Capture copies counter into capture register and sets capture flag.
//- Modes using capture register as TOP disable capture.
//- Clock select 0 stops, 1 undivided, 2-5 divide 8/64/256/1024.
//- Clock select 6 and 7 count external pin falling and rising edges.
//- External pin counts even when driven as an output.
//- Control C: force bits 7:5 write-only, low bits read zero.
module tmc_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Pins
  input wire logic capture_pin_in,
  input wire logic ext_count_pin_in,
  // Status
  output logic [15:0] count_out,
  output logic [15:0] compare_value_a_out,
  output logic [2:0] force_compare_out,
  output logic irq_out
);
  import tmc_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [15:0] cnt_reg;
  logic [15:0] oca_reg;
  logic [15:0] oca_buf_reg;
  logic [15:0] cap_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic [7:0] hi_tmp_reg;
  logic [9:0] pre_reg;
  logic down_reg;
  logic [2:0] cap_sync_reg;
  logic [2:0] ext_sync_reg;
  logic cap_stable_reg;
  logic ext_stable_reg;
  logic [TMC_FILT_SAMPLES-1:0] filt_hist_reg;
  logic cap_filt_reg;
  logic cap_prev_reg;
  logic [7:0] rdata_reg;
  logic [2:0] foc_reg;
  logic irq_reg;

  wire [3:0] waveform_mode_sel = {ctrl_b_reg[4:TMC_B_WGM_HI], ctrl_a_reg[1:0]};
  wire [2:0] clock_source_sel = ctrl_b_reg[TMC_B_CS +: 3];
  wire capture_filter_en = ctrl_b_reg[TMC_B_FILT];
  wire capture_edge_sel = ctrl_b_reg[TMC_B_EDGE];

  // Mode decode
  logic [15:0] top_val;
  tmc_upd_t upd_pt;
  logic ovf_at_top;
  logic ovf_at_bot;
  logic dual_slope;
  logic top_is_cap;
  always_comb begin
    top_val = TMC_TOP_MAX;
    upd_pt = TMC_UPD_NOW;
    ovf_at_top = 1'b0;
    ovf_at_bot = 1'b0;
    dual_slope = 1'b0;
    top_is_cap = 1'b0;
    case (waveform_mode_sel)
      4'h0: top_val = TMC_TOP_MAX;
      4'h1, 4'h2, 4'h3: begin
        top_val = (waveform_mode_sel == 4'h1) ? TMC_TOP_8 :
                  (waveform_mode_sel == 4'h2) ? TMC_TOP_9 : TMC_TOP_10;
        upd_pt = TMC_UPD_TOP;
        ovf_at_bot = 1'b1;
        dual_slope = 1'b1;
      end
      4'h4: top_val = oca_reg;
      4'h5, 4'h6, 4'h7: begin
        top_val = (waveform_mode_sel == 4'h5) ? TMC_TOP_8 :
                  (waveform_mode_sel == 4'h6) ? TMC_TOP_9 : TMC_TOP_10;
        upd_pt = TMC_UPD_BOT;
        ovf_at_top = 1'b1;
      end
      4'h8, 4'h9: begin
        top_val = (waveform_mode_sel == 4'h8) ? cap_reg : oca_reg;
        top_is_cap = (waveform_mode_sel == 4'h8);
        upd_pt = TMC_UPD_BOT;
        ovf_at_bot = 1'b1;
        dual_slope = 1'b1;
      end
      4'ha, 4'hb: begin
        top_val = (waveform_mode_sel == 4'ha) ? cap_reg : oca_reg;
        top_is_cap = (waveform_mode_sel == 4'ha);
        upd_pt = TMC_UPD_TOP;
        ovf_at_bot = 1'b1;
        dual_slope = 1'b1;
      end
      4'hc: begin
        top_val = cap_reg;
        top_is_cap = 1'b1;
      end
      4'he, 4'hf: begin
        top_val = (waveform_mode_sel == 4'he) ? cap_reg : oca_reg;
        top_is_cap = (waveform_mode_sel == 4'he);
        upd_pt = TMC_UPD_BOT;
        ovf_at_top = 1'b1;
      end
      // Mode 13 reserved: behaves as plain counting
      default: top_val = TMC_TOP_MAX;
    endcase
  end

  // Clock source
  wire ext_rise = ext_sync_reg[2] & ext_sync_reg[1] & ~ext_stable_reg;
  wire ext_fall = ~ext_sync_reg[2] & ~ext_sync_reg[1] & ext_stable_reg;
  logic tick;
  always_comb begin
    case (clock_source_sel)
      3'd0: tick = 1'b0;
      3'd1: tick = 1'b1;
      3'd2: tick = (pre_reg[2:0] == TMC_DIV8[2:0]);
      3'd3: tick = (pre_reg[5:0] == TMC_DIV64[5:0]);
      3'd4: tick = (pre_reg[7:0] == TMC_DIV256[7:0]);
      3'd5: tick = (pre_reg == TMC_DIV1024);
      3'd6: tick = ext_fall;
      default: tick = ext_rise;
    endcase
  end

  // Counter sequencing
  wire at_top = (cnt_reg == top_val);
  wire at_bot = (cnt_reg == 16'h0000);
  wire at_max = (cnt_reg == TMC_TOP_MAX);
  logic [15:0] cnt_next;
  logic down_next;
  always_comb begin
    down_next = down_reg;
    if (dual_slope) begin
      if (at_top) down_next = 1'b1;
      else if (at_bot) down_next = 1'b0;
      cnt_next = down_next ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
      if (at_top && at_bot) cnt_next = cnt_reg;
    end else begin
      down_next = 1'b0;
      cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end
  // Overflow point per mode
  wire ovf_event = tick & ((ovf_at_top & at_top) | (ovf_at_bot & at_bot & down_reg) |
                           (~ovf_at_top & ~ovf_at_bot & at_max));
  wire upd_event = tick & (((upd_pt == TMC_UPD_TOP) & at_top) | ((upd_pt == TMC_UPD_BOT) & at_bot));

  // Capture path
  wire cap_in = capture_filter_en ? cap_filt_reg : cap_stable_reg;
  wire cap_edge = capture_edge_sel ? (cap_in & ~cap_prev_reg) : (~cap_in & cap_prev_reg);
  wire cap_event = cap_edge & ~top_is_cap;
  wire filt_all_hi = &filt_hist_reg;
  wire filt_all_lo = ~|filt_hist_reg;

  // Register port decode
  wire wr_a = wr_in & (addr_in == TMC_ADDR_CTRL_A);
  wire wr_b = wr_in & (addr_in == TMC_ADDR_CTRL_B);
  wire wr_c = wr_in & (addr_in == TMC_ADDR_CTRL_C);
  wire wr_cl = wr_in & (addr_in == TMC_ADDR_CNT_LO);
  wire wr_ch = wr_in & (addr_in == TMC_ADDR_CNT_HI);
  wire wr_ol = wr_in & (addr_in == TMC_ADDR_OCA_LO);
  wire wr_oh = wr_in & (addr_in == TMC_ADDR_OCA_HI);
  wire wr_pl = wr_in & (addr_in == TMC_ADDR_CAP_LO);
  wire wr_mask = wr_in & (addr_in == TMC_ADDR_MASK);
  wire rd_st = rd_in & (addr_in == TMC_ADDR_STATUS);
  wire [15:0] wr_word = {hi_tmp_reg, wdata_in};
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_in)
      TMC_ADDR_CTRL_A: rd_mux = ctrl_a_reg;
      TMC_ADDR_CTRL_B: rd_mux = ctrl_b_reg & TMC_B_WMASK;
      TMC_ADDR_CTRL_C: rd_mux = 8'h00;
      TMC_ADDR_CNT_LO: rd_mux = cnt_reg[7:0];
      TMC_ADDR_CNT_HI: rd_mux = cnt_reg[15:8];
      TMC_ADDR_OCA_LO: rd_mux = oca_reg[7:0];
      TMC_ADDR_OCA_HI: rd_mux = oca_reg[15:8];
      TMC_ADDR_CAP_LO: rd_mux = cap_reg[7:0];
      TMC_ADDR_CAP_HI: rd_mux = cap_reg[15:8];
      TMC_ADDR_STATUS: rd_mux = status_reg;
      TMC_ADDR_MASK: rd_mux = mask_reg;
      default: rd_mux = 8'h00;
    endcase
  end
  wire [7:0] status_next = (status_reg & ~(rd_st ? 8'hff : 8'h00)) |
                           ({7'h00, ovf_event} << TMC_ST_OVF) | ({7'h00, cap_event} << TMC_ST_CAP);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_a_reg <= TMC_RESET_VAL;
      ctrl_b_reg <= TMC_RESET_VAL;
      mask_reg <= TMC_RESET_VAL;
      hi_tmp_reg <= TMC_RESET_VAL;
      rdata_reg <= TMC_RESET_VAL;
      foc_reg <= 3'h0;
    end else if (clk_en_in) begin
      if (wr_a) ctrl_a_reg <= wdata_in;
      if (wr_b) ctrl_b_reg <= wdata_in & TMC_B_WMASK;
      if (wr_mask) mask_reg <= wdata_in;
      // Counter and compare A high bytes staged, low byte write commits the word
      if (wr_ch || wr_oh) hi_tmp_reg <= wdata_in;
      if (rd_in) rdata_reg <= rd_mux;
      foc_reg <= wr_c ? wdata_in[TMC_C_FOC_A:TMC_C_FOC_C] : 3'h0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= 16'h0000;
      down_reg <= 1'b0;
      pre_reg <= 10'h000;
    end else if (clk_en_in) begin
      pre_reg <= (clock_source_sel == 3'd0) ? 10'h000 : pre_reg + 10'h001;
      if (wr_cl) cnt_reg <= wr_word;
      else if (tick) cnt_reg <= cnt_next;
      if (tick) down_reg <= down_next;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      oca_buf_reg <= 16'h0000;
      oca_reg <= 16'h0000;
    end else if (clk_en_in) begin
      if (wr_ol) oca_buf_reg <= wr_word;
      // Immediate modes bypass the buffer
      if (wr_ol && upd_pt == TMC_UPD_NOW) oca_reg <= wr_word;
      else if (upd_event) oca_reg <= oca_buf_reg;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cap_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      cap_stable_reg <= 1'b0;
      ext_stable_reg <= 1'b0;
      filt_hist_reg <= '0;
      cap_filt_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else if (clk_en_in) begin
      cap_sync_reg <= {cap_sync_reg[1:0], capture_pin_in};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_count_pin_in};
      if (cap_sync_reg[2] == cap_sync_reg[1]) cap_stable_reg <= cap_sync_reg[2];
      if (ext_sync_reg[2] == ext_sync_reg[1]) ext_stable_reg <= ext_sync_reg[2];
      filt_hist_reg <= {filt_hist_reg[TMC_FILT_SAMPLES-2:0], cap_stable_reg};
      if (filt_all_hi) cap_filt_reg <= 1'b1;
      else if (filt_all_lo) cap_filt_reg <= 1'b0;
      cap_prev_reg <= cap_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cap_reg <= 16'h0000;
      status_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (cap_event) cap_reg <= cnt_reg;
      else if (wr_pl) cap_reg <= wr_word;
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign rdata_out = rdata_reg;
  assign count_out = cnt_reg;
  assign compare_value_a_out = oca_reg;
  assign force_compare_out = foc_reg;
  assign irq_out = irq_reg;

  a_cap_copy: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && cap_event |=> cap_reg == $past(cnt_reg) && status_reg[TMC_ST_CAP])
    else $error("capture not recorded");
  a_cap_blocked: assert property (@(posedge clk_in) disable iff (reset_in)
    top_is_cap |-> !cap_event)
    else $error("capture active in capture-top mode");
  a_rsvd_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    !ctrl_b_reg[TMC_B_RSVD])
    else $error("reserved bit set");
  a_ctrl_c_read: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && rd_in && addr_in == TMC_ADDR_CTRL_C |=> rdata_out == 8'h00)
    else $error("control C read nonzero");
  a_top_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h6 |-> top_val == TMC_TOP_9)
    else $error("fixed top wrong");
  a_stop_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && clock_source_sel == 3'd0 && !wr_cl |=> cnt_reg == $past(cnt_reg))
    else $error("stopped counter moved");
  a_div8_tick: assert property (@(posedge clk_in) disable iff (reset_in)
    clock_source_sel == 3'd2 && tick |-> pre_reg[2:0] == 3'h7)
    else $error("prescale tick off");
  a_ovf_fast: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && waveform_mode_sel == 4'h5 && tick && cnt_reg == TMC_TOP_8 |=> status_reg[TMC_ST_OVF])
    else $error("fast pwm overflow missing");
  a_mode_word: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && wr_b |=> waveform_mode_sel[3:2] == $past(wdata_in[4:3]))
    else $error("mode word wrong");
  // Per-mode decode checks (TOP sources, overflow and update points), then filter, edge, interrupt, status read, clock and force checks
  a_top_normal: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h0 |-> top_val == TMC_TOP_MAX)
    else $error("normal top wrong");
  a_ovf_normal: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && waveform_mode_sel == 4'h0 && tick && at_max |=> status_reg[TMC_ST_OVF])
    else $error("normal overflow missing");
  a_top_ctc_a: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h4 |-> top_val == oca_reg)
    else $error("match-clear top wrong");
  a_top_ctc_cap: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'hc |-> top_val == cap_reg && top_is_cap)
    else $error("capture-clear top wrong");
  a_upd_now: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && wr_ol && (waveform_mode_sel == 4'h4 || waveform_mode_sel == 4'hc) |=> oca_reg == $past(wr_word))
    else $error("immediate update missing");
  a_top_pc8: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h1 |-> top_val == TMC_TOP_8)
    else $error("8-bit top wrong");
  a_top_fast10: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h7 |-> top_val == TMC_TOP_10)
    else $error("10-bit top wrong");
  a_pc_update: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && (waveform_mode_sel == 4'h1 || waveform_mode_sel == 4'ha) && tick && at_top
    |=> oca_reg == $past(oca_buf_reg))
    else $error("phase-correct update missing");
  a_pc_ovf_bot: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && waveform_mode_sel == 4'h3 && tick && at_bot && down_reg |=> status_reg[TMC_ST_OVF])
    else $error("phase-correct overflow missing");
  a_pfc_update: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && (waveform_mode_sel == 4'h8 || waveform_mode_sel == 4'h9) && tick && at_bot
    |=> oca_reg == $past(oca_buf_reg))
    else $error("frequency-correct update missing");
  a_pfc_top: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'h8 |-> top_val == cap_reg)
    else $error("frequency-correct top wrong");
  a_fast_update: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && waveform_mode_sel == 4'hf && tick && at_bot |=> oca_reg == $past(oca_buf_reg))
    else $error("fast pwm update missing");
  a_filt_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && !filt_all_hi && !filt_all_lo |=> cap_filt_reg == $past(cap_filt_reg))
    else $error("filter changed early");
  a_edge_rise: assert property (@(posedge clk_in) disable iff (reset_in)
    capture_edge_sel && !top_is_cap && cap_in && !cap_prev_reg |-> cap_event)
    else $error("rising capture missed");
  a_cap_irq: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && |(status_next & mask_reg) |=> irq_out)
    else $error("interrupt missing");
  a_status_read: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && rd_st |=> rdata_out == $past(status_reg))
    else $error("status read wrong");
  a_cap_off_fast: assert property (@(posedge clk_in) disable iff (reset_in)
    waveform_mode_sel == 4'he |-> top_is_cap)
    else $error("capture not disabled");
  a_div1_tick: assert property (@(posedge clk_in) disable iff (reset_in)
    clock_source_sel == 3'd1 |-> tick)
    else $error("undivided tick missing");
  a_ext_rise: assert property (@(posedge clk_in) disable iff (reset_in)
    clock_source_sel == 3'd7 |-> tick == ext_rise)
    else $error("external rise tick wrong");
  a_foc_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && wr_c |=> force_compare_out == $past(wdata_in[7:5]))
    else $error("force strobe wrong");
endmodule : tmc_timer

// >>> tmc_pin_model.sv
`timescale 1ns/1ps
module tmc_pin_model (
  // Pins towards the timer
  output logic capture_pin_out,
  output logic ext_count_pin_out
);
  // Off-grid skew keeps pin edges 1.3 ns after the rising clock edge
  localparam realtime PIN_SKEW = 1.3;
  initial begin
    capture_pin_out = 1'b0;
    ext_count_pin_out = 1'b0;
  end
  task automatic drive_capture(input logic level);
    #(PIN_SKEW) capture_pin_out = level;
  endtask : drive_capture
  task automatic drive_count(input logic level);
    #(PIN_SKEW) ext_count_pin_out = level;
  endtask : drive_count
endmodule : tmc_pin_model

// >>> tmc_timer_tb.sv
`timescale 1ns/1ps
module tmc_timer_tb;
  import tmc_pkg::*;
  logic clk_in, reset_in, clk_en_in, wr_in, rd_in, cap_pin, cnt_pin, irq_out, saw_force, irq_en;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, rv;
  logic [15:0] count_out, compare_value_a_out, c0, c1, c2, mx, prev;
  logic [2:0] force_compare_out;
  int errors, checks_done;
  int div_tab [5] = '{1, 8, 64, 256, 1024};
  logic [3:0] mode_tab [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf, 4'h9, 4'hb};
  logic [15:0] top_tab [10] = '{TMC_TOP_8, TMC_TOP_9, TMC_TOP_10, 16'h0023, TMC_TOP_8, TMC_TOP_9, TMC_TOP_10,
    16'h0027, 16'h0028, 16'h0029};
  logic [3:0] tie_tab [4] = '{4'h8, 4'ha, 4'hc, 4'he};

  tmc_timer u_tmc_timer (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .capture_pin_in(cap_pin),
    .ext_count_pin_in(cnt_pin), .count_out(count_out), .compare_value_a_out(compare_value_a_out),
    .force_compare_out(force_compare_out), .irq_out(irq_out));
  tmc_pin_model u_tmc_pin_model (.capture_pin_out(cap_pin), .ext_count_pin_out(cnt_pin));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (force_compare_out === 3'b111) saw_force <= 1'b1;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge clk_in);
  endtask : rd
  task automatic chk_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(what, {8'h00, exp}, {8'h00, rv});
  endtask : chk_reg
  task automatic smp(output logic [15:0] v);
    #1;
    v = count_out;
    @(posedge clk_in);
  endtask : smp
  // Low byte write commits the staged high byte
  task automatic wr16(input logic [3:0] hi_addr, input logic [15:0] v);
    wr(hi_addr, v[15:8]);
    wr(hi_addr - 4'h1, v[7:0]);
  endtask : wr16
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
    wr(TMC_ADDR_CTRL_A, {6'h00, m[1:0]});
    wr(TMC_ADDR_CTRL_B, {3'b010, m[3:2], cs});
  endtask : set_mode
  task automatic cap_step(input logic [7:0] ctrl_b, input logic lvl, input logic glitch, input logic exp);
    wr(TMC_ADDR_CTRL_B, ctrl_b);
    u_tmc_pin_model.drive_capture(lvl);
    if (glitch) begin
      cyc(2);
      u_tmc_pin_model.drive_capture(~lvl);
    end
    cyc(20);
    #1;
    chk("capture irq", {15'h0, exp & irq_en}, {15'h0, irq_out});
    @(posedge clk_in);
    chk_reg("capture flag", TMC_ADDR_STATUS, {6'h00, exp, 1'b0});
  endtask : cap_step

  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    errors = 0;
    checks_done = 0;
    saw_force = 1'b0;
    irq_en = 1'b1;
    prev = 16'h0000;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a < 12; a++) chk_reg("reset value", 4'(a), TMC_RESET_VAL); // Incl. unmapped
    wr(TMC_ADDR_CTRL_B, 8'h20);
    chk_reg("ctrl b", TMC_ADDR_CTRL_B, 8'h00); // Reserved bit
    wr(TMC_ADDR_CTRL_C, 8'he0);
    chk_reg("ctrl c", TMC_ADDR_CTRL_C, 8'h00); // Force bits
    chk("force strobe", 16'h0001, {15'h0, saw_force}); // Strobe seen
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      wr(TMC_ADDR_CTRL_B, 8'((i + 1) % 6));
      cyc(8);
      smp(c0);
      cyc(4 * div_tab[i % 5] - 1);
      smp(c1);
      chk("prescaled ticks", (i < 5) ? 16'h0004 : 16'h0000, c1 - c0);
    end
    $display("prescaler test done");
    for (int i = 0; i < 2; i++) begin
      wr(TMC_ADDR_CTRL_B, 8'(6 + i));
      cyc(8);
      smp(c0);
      u_tmc_pin_model.drive_count(1'b1);
      cyc(10);
      smp(c1);
      u_tmc_pin_model.drive_count(1'b0);
      cyc(10);
      smp(c2);
      chk("ticks on rise", 16'(i), c1 - c0);
      chk("ticks on fall", 16'(1 - i), c2 - c1);
    end
    $display("external clock test done");
    wr(TMC_ADDR_CTRL_B, 8'h00);
    wr16(TMC_ADDR_CNT_HI, 16'h1234);
    wr(TMC_ADDR_MASK, 8'h02);
    rd(TMC_ADDR_STATUS, rv);
    cap_step(8'h40, 1'b1, 1'b0, 1'b1); // Rising edge
    #1;
    chk("irq after clear", 16'h0000, {15'h0, irq_out});
    @(posedge clk_in);
    chk_reg("capture lo", TMC_ADDR_CAP_LO, 8'h34);
    chk_reg("capture hi", TMC_ADDR_CAP_HI, 8'h12);
    cap_step(8'h40, 1'b0, 1'b0, 1'b0); // Falling ignored
    cap_step(8'h00, 1'b1, 1'b0, 1'b0); // Rising ignored
    cap_step(8'h00, 1'b0, 1'b0, 1'b1); // Falling edge
    cap_step(8'hc0, 1'b1, 1'b1, 1'b0); // Short pulse filtered
    cap_step(8'hc0, 1'b1, 1'b0, 1'b1); // Long pulse passes filter
    cap_step(8'h40, 1'b0, 1'b1, 1'b1); // Short pulse unfiltered
    irq_en = 1'b0;
    wr(TMC_ADDR_MASK, 8'h00);
    cap_step(8'h00, 1'b0, 1'b0, 1'b1); // Masked flag
    for (int i = 0; i < 4; i++) begin
      set_mode(tie_tab[i], 3'b000);
      u_tmc_pin_model.drive_capture(1'b1);
      cyc(20);
      u_tmc_pin_model.drive_capture(1'b0);
      cyc(20);
      chk_reg("capture disabled", TMC_ADDR_STATUS, 8'h00);
    end
    $display("capture test done");
    for (int i = 0; i < 10; i++) begin
      wr(TMC_ADDR_CTRL_B, 8'h00);
      set_mode(mode_tab[i], 3'b000);
      wr16(TMC_ADDR_CNT_HI, 16'h0008);
      wr16(TMC_ADDR_OCA_HI, 16'h0020 + 16'(i));
      #1;
      chk("compare a held", (i == 3) ? 16'h0023 : prev, compare_value_a_out);
      @(posedge clk_in);
      rd(TMC_ADDR_STATUS, rv);
      set_mode(mode_tab[i], 3'b001);
      mx = 16'h0000;
      repeat (2200) begin
        @(posedge clk_in);
        #1;
        if (count_out > mx) mx = count_out;
      end
      @(posedge clk_in);
      chk("top", top_tab[i], mx);
      chk("compare a loaded", 16'h0020 + 16'(i), compare_value_a_out);
      chk_reg("overflow", TMC_ADDR_STATUS, {7'h00, mode_tab[i] != 4'h4});
      prev = 16'h0020 + 16'(i);
    end
    wr(TMC_ADDR_CTRL_B, 8'h00);
    set_mode(4'h0, 3'b000);
    wr16(TMC_ADDR_CNT_HI, 16'hfffe);
    rd(TMC_ADDR_STATUS, rv);
    set_mode(4'h0, 3'b001);
    cyc(8);
    wr(TMC_ADDR_CTRL_B, 8'h00);
    chk_reg("overflow at max", TMC_ADDR_STATUS, 8'h01);
    $display("mode test done");
    report_and_stop();
  end

  // Tests need about 28k cycles
  initial begin
    cyc(60000);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end
endmodule : tmc_timer_tb
